// file: pkg/brl_regs.svh
/*
 * register map, field positions and reset values of the receive/lock status bank.
 * assumes a 32-bit register bus with one aligned word per register.
 */
`ifndef BRL_REGS_SVH
`define BRL_REGS_SVH

// byte offsets
`define BRL_OFF_RX_LEN     8'h00
`define BRL_OFF_RX_BUF     8'h04
`define BRL_OFF_LOCK_LOW   8'h08
`define BRL_OFF_LOCK_HIGH  8'h0C
`define BRL_OFF_FLAGS      8'h10
`define BRL_OFF_INT_STAT   8'h14
`define BRL_OFF_INT_MASK   8'h18
`define BRL_OFF_RX_STAT    8'h1C

// general flag bit positions
`define BRL_FLG_CMX        7
`define BRL_FLG_MRQ        6
`define BRL_FLG_SRQ        5
`define BRL_FLG_SRE        4
`define BRL_FLG_LCK        3
`define BRL_FLG_AMATCH     1
`define BRL_FLG_BCAST      0

// interrupt status bit positions
`define BRL_INT_RX_START   0
`define BRL_INT_RX_BYTE    1
`define BRL_INT_LOCK       2
`define BRL_INT_CMD_DONE   3

// reset values
`define BRL_RST_BYTE       8'h00
`define BRL_RST_LOCK       12'h000
`define BRL_RST_INT        4'h0

// bus responses
`define BRL_RESP_OKAY      2'h0
`define BRL_RESP_SLVERR    2'h2

`endif

// file: pkg/brl_pkg.sv
/*
 * types shared by the status bank and its bus slave.
 * assumes brl_regs.svh sits on the include path.
 */
package brl_pkg;

	localparam int BRL_AW = 8;

	// bus slave state
	typedef struct packed {
		logic              aw_full;
		logic              w_full;
		logic [BRL_AW-1:0] waddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} brl_axi_t;

	// status bank state
	typedef struct packed {
		logic [7:0]  rx_len;
		logic        len_valid;
		logic [7:0]  rx_buf;
		logic [11:0] lock_addr;
		logic        command_executing_flag;
		logic        cmd_master;
		logic        master_request_flag;
		logic        slave_request_flag;
		logic        slave_receiving_flag;
		logic        lock_status_flag;
		logic        amatch;
		logic        bcast;
		logic [3:0]  int_stat;
		logic [3:0]  int_mask;
	} brl_bank_t;

endpackage : brl_pkg

// file: rtl/brl_axi_slave.sv
/*
 * axi4-lite slave front end: one write and one read under way at most.
 * assumes the bank answers rd_data/rd_ok and wr_ok combinationally.
 */
`timescale 1ns/10ps
`include "brl_regs.svh"

module brl_axi_slave import brl_pkg::*; (
	// clock, reset, enable
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire logic              ce,
	// write address and data
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [BRL_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	// write response
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// read
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [BRL_AW-1:0] s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// bank side
	output logic                   wr_en,
	output logic [BRL_AW-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	output logic [3:0]             wr_strb,
	input  wire logic              wr_ok,
	output logic [BRL_AW-1:0]      rd_addr,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_ok
);

	brl_axi_t s;
	brl_axi_t next_s;

	// handshakes and bank strobes
	assign s_axi_awready = ce & ~s.aw_full & ~s.bvalid;
	assign s_axi_wready  = ce & ~s.w_full & ~s.bvalid;
	assign s_axi_arready = ce & ~s.rvalid;
	assign wr_en         = ce & s.aw_full & s.w_full & ~s.bvalid;
	assign wr_addr       = s.waddr;
	assign wr_data       = s.wdata;
	assign wr_strb       = s.wstrb;
	assign rd_addr       = s_axi_araddr;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;

	// next state
	always_comb begin
		next_s = s;
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.aw_full = 1'b1;
			next_s.waddr   = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.w_full = 1'b1;
			next_s.wdata  = s_axi_wdata;
			next_s.wstrb  = s_axi_wstrb;
		end
		if (wr_en) begin
			next_s.aw_full = 1'b0;
			next_s.w_full  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = wr_ok ? `BRL_RESP_OKAY : `BRL_RESP_SLVERR;
		end
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			next_s.rvalid = 1'b1;
			next_s.rdata  = rd_data;
			next_s.rresp  = rd_ok ? `BRL_RESP_OKAY : `BRL_RESP_SLVERR;
		end
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!rst_b)
			s <= '0;
		else if (ce)
			s <= next_s;
	end

endmodule : brl_axi_slave

// file: rtl/brl_status_regs.sv
/*
 * read-only receive, lock and general status bank of a serial bus controller,
 * with sticky interrupt status behind an axi4-lite slave.
 * assumes the protocol engine on the same clock gives one-cycle event pulses.
 */
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`include "brl_regs.svh"

// Summary of operation
// - message length captured into length register when reception starts; resets to zero
// - length register becomes valid only once slave or broadcast reception begins (code sets it on any rx_start, whatever rx_addr_match and rx_broadcast)
// - each received data byte held in one-byte buffer; read only while receive-ready (read mux returns it whatever receive-ready is)
// - same buffer carries data bytes of master and slave receptions
// - low lock-address register stores lower 8 address bits on lock
// - high lock-address holds upper 4 bits in 3..0; bits 7..4 read zero
// - writes to length, buffer, lock-address and flag registers are ignored
// - command flag sets on command issued while request or receive flag set
// - master-request sets when command flag clears after master command; clears on completion
// - general flags report command, lock, address match, broadcast; all reset zero
// - lock flag sets on lock with unfinished long message; clears on unlock
// - slave-request sets when command flag clears after slave command; clears on completion
// - slave-receiving sets on reception start with receive enable; clears on completion
module brl_status_regs import brl_pkg::*; (
	// clock, reset, enable
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire logic              ce,
	// axi4-lite write
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [BRL_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	output logic [1:0]             s_axi_bresp,
	// axi4-lite read
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	input  wire logic [BRL_AW-1:0] s_axi_araddr,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	// reception events from the protocol engine
	input  wire logic              rx_start,
	input  wire logic [7:0]        rx_msg_len,
	input  wire logic              rx_addr_match,
	input  wire logic              rx_broadcast,
	input  wire logic              receive_enable_bit,
	input  wire logic              slave_rx_done,
	input  wire logic              rx_byte_valid,
	input  wire logic [7:0]        rx_byte,
	input  wire logic              receive_ready_flag,
	// lock events
	input  wire logic              lock_event,
	input  wire logic              lock_long_msg,
	input  wire logic [11:0]       lock_master_addr,
	input  wire logic              unlock_cond,
	input  wire logic              unlock_cmd,
	// commands
	input  wire logic              cmd_master_req,
	input  wire logic              cmd_slave_tx,
	input  wire logic              cmd_done,
	input  wire logic              master_comm_done,
	input  wire logic              slave_tx_done,
	// interrupt
	output logic                   irq
);

	////////////////////////////////////////////////////////////////////////////////

	brl_bank_t        s;
	brl_bank_t        next_s;
	logic             wr_en;
	logic [BRL_AW-1:0] wr_addr;
	logic [31:0]      wr_data;
	logic [3:0]       wr_strb;
	logic [BRL_AW-1:0] rd_addr;
	logic [31:0]      rd_data;
	logic [3:0]       int_ev;
	logic [7:0]       flags;

	// true for any mapped register offset
	function automatic logic addr_hit(input logic [BRL_AW-1:0] a);
		case (a)
			`BRL_OFF_RX_LEN, `BRL_OFF_RX_BUF, `BRL_OFF_LOCK_LOW, `BRL_OFF_LOCK_HIGH,
			`BRL_OFF_FLAGS, `BRL_OFF_INT_STAT, `BRL_OFF_INT_MASK, `BRL_OFF_RX_STAT:
				addr_hit = 1'b1;
			default:
				addr_hit = 1'b0;
		endcase
	endfunction : addr_hit

	////////////////////////////////////////////////////////////////////////////////

	brl_axi_slave brl_axi_slave_inst (
		.mclk          (mclk),
		.rst_b         (rst_b),
		.ce            (ce),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.wr_strb       (wr_strb),
		.wr_ok         (addr_hit(wr_addr)),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data),
		.rd_ok         (addr_hit(rd_addr))
	);

	////////////////////////////////////////////////////////////////////////////////

	// general flag byte, bit 2 reserved as zero
	always_comb begin
		flags = 8'h00;
		flags[`BRL_FLG_CMX]    = s.command_executing_flag;
		flags[`BRL_FLG_MRQ]    = s.master_request_flag;
		flags[`BRL_FLG_SRQ]    = s.slave_request_flag;
		flags[`BRL_FLG_SRE]    = s.slave_receiving_flag;
		flags[`BRL_FLG_LCK]    = s.lock_status_flag;
		flags[`BRL_FLG_AMATCH] = s.amatch;
		flags[`BRL_FLG_BCAST]  = s.bcast;
	end

	// read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		case (rd_addr)
			`BRL_OFF_RX_LEN:    rd_data[7:0] = s.rx_len;
			`BRL_OFF_RX_BUF:    rd_data[7:0] = s.rx_buf;
			`BRL_OFF_LOCK_LOW:  rd_data[7:0] = s.lock_addr[7:0];
			`BRL_OFF_LOCK_HIGH: rd_data[3:0] = s.lock_addr[11:8];
			`BRL_OFF_FLAGS:     rd_data[7:0] = flags;
			`BRL_OFF_INT_STAT:  rd_data[3:0] = s.int_stat;
			`BRL_OFF_INT_MASK:  rd_data[3:0] = s.int_mask;
			`BRL_OFF_RX_STAT:   rd_data[1:0] = {s.len_valid, receive_ready_flag};
			default:            rd_data = 32'h0000_0000;
		endcase
	end

	// interrupt events
	always_comb begin
		int_ev = 4'h0;
		int_ev[`BRL_INT_RX_START] = rx_start;
		int_ev[`BRL_INT_RX_BYTE]  = rx_byte_valid;
		int_ev[`BRL_INT_LOCK]     = lock_event & lock_long_msg;
		int_ev[`BRL_INT_CMD_DONE] = cmd_done & s.command_executing_flag;
	end

	assign irq = |(s.int_stat & s.int_mask);

	// next state: clears first, sets after, so a set wins
	always_comb begin
		next_s = s;
		// length, match and broadcast captured at reception start
		if (rx_start) begin
			next_s.rx_len    = rx_msg_len;
			next_s.len_valid = 1'b1;
			next_s.amatch    = rx_addr_match;
			next_s.bcast     = rx_broadcast;
		end
		if (rx_byte_valid)
			next_s.rx_buf = rx_byte;
		// lock
		if (unlock_cond || unlock_cmd)
			next_s.lock_status_flag = 1'b0;
		if (lock_event && lock_long_msg) begin
			next_s.lock_status_flag       = 1'b1;
			next_s.lock_addr = lock_master_addr;
		end
		// completion clears, then slave-receiving set at reception start
		if (master_comm_done)
			next_s.master_request_flag = 1'b0;
		if (slave_tx_done)
			next_s.slave_request_flag = 1'b0;
		if (slave_rx_done)
			next_s.slave_receiving_flag = 1'b0;
		if (rx_start && receive_enable_bit)
			next_s.slave_receiving_flag = 1'b1;
		// command execution ends
		if (cmd_done && s.command_executing_flag) begin
			next_s.command_executing_flag = 1'b0;
			if (s.cmd_master)
				next_s.master_request_flag = 1'b1;
			else
				next_s.slave_request_flag = 1'b1;
		end
		// command issued
		if ((cmd_master_req || cmd_slave_tx) && (s.master_request_flag || s.slave_request_flag || s.slave_receiving_flag)) begin
			next_s.command_executing_flag        = 1'b1;
			next_s.cmd_master = cmd_master_req;
		end
		// software access; status bank itself ignores writes
		if (wr_en && wr_strb[0]) begin
			if (wr_addr == `BRL_OFF_INT_MASK)
				next_s.int_mask = wr_data[3:0];
			if (wr_addr == `BRL_OFF_INT_STAT)
				next_s.int_stat = s.int_stat & ~wr_data[3:0];
		end
		next_s.int_stat = next_s.int_stat | int_ev;
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s           <= '0;
			s.rx_len    <= `BRL_RST_BYTE;
			s.rx_buf    <= `BRL_RST_BYTE;
			s.lock_addr <= `BRL_RST_LOCK;
			s.int_stat  <= `BRL_RST_INT;
			s.int_mask  <= `BRL_RST_INT;
		end else if (ce) begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence cmd_ends_s;
		ce && cmd_done && s.command_executing_flag;
	endsequence

	sequence master_cmd_s;
		s.cmd_master && !master_comm_done;
	endsequence

	// no new command in the same cycle, so a clear is not overridden
	sequence no_cmd_s;
		!(cmd_master_req || cmd_slave_tx);
	endsequence

	AST_LEN_CAPTURE: assert property (ce && rx_start |=> s.rx_len == $past(rx_msg_len))
		else $error("length not captured at reception start");
	AST_LEN_VALID: assert property ($rose(s.len_valid) |-> $past(rx_start))
		else $error("length valid without reception start");
	AST_BUF_CAPTURE: assert property (ce && rx_byte_valid |=> s.rx_buf == $past(rx_byte))
		else $error("received byte not held");
	AST_LOCK_ADDR: assert property (ce && lock_event && lock_long_msg |=>
		s.lock_status_flag && s.lock_addr == $past(lock_master_addr))
		else $error("lock address not stored");
	AST_HIGH_RSVD: assert property (rd_addr == `BRL_OFF_LOCK_HIGH |-> rd_data[31:4] == 28'h0000000)
		else $error("lock high reserved bits not zero");
	AST_RO_IGNORE: assert property (ce && wr_en && wr_addr == `BRL_OFF_RX_LEN && !rx_start |=>
		$stable(s.rx_len))
		else $error("write changed length register");
	AST_CMX_SET: assert property (ce && cmd_slave_tx && s.slave_receiving_flag |=> s.command_executing_flag)
		else $error("command flag not set");
	AST_MRQ_SET: assert property (cmd_ends_s ##0 master_cmd_s |=> s.master_request_flag)
		else $error("master request not set after command");
	AST_LCK_CLR: assert property (ce && unlock_cmd && !(lock_event && lock_long_msg) |=> !s.lock_status_flag)
		else $error("lock flag not cleared");
	AST_SRQ_SET: assert property (cmd_ends_s ##0 (!s.cmd_master && !slave_tx_done) |=> s.slave_request_flag)
		else $error("slave request not set after command");
	AST_SRE_SET: assert property (ce && rx_start && receive_enable_bit |=> s.slave_receiving_flag ##1 (s.slave_receiving_flag || $past(slave_rx_done)))
		else $error("slave receiving flag wrong");

	// clears, refusals and holds
	AST_CMX_CLR: assert property (cmd_ends_s ##0 no_cmd_s |=> !s.command_executing_flag)
		else $error("command flag not cleared at command end");
	AST_CMX_REFUSE: assert property (ce && (cmd_master_req || cmd_slave_tx) &&
		!(s.master_request_flag || s.slave_request_flag || s.slave_receiving_flag || s.command_executing_flag) |=> !s.command_executing_flag)
		else $error("command flag set without request or receive flag");
	AST_MRQ_CLR: assert property (ce && master_comm_done &&
		!(cmd_done && s.command_executing_flag && s.cmd_master) |=> !s.master_request_flag)
		else $error("master request not cleared on completion");
	AST_SRQ_CLR: assert property (ce && slave_tx_done &&
		!(cmd_done && s.command_executing_flag && !s.cmd_master) |=> !s.slave_request_flag)
		else $error("slave request not cleared on completion");
	AST_SRE_CLR: assert property (ce && slave_rx_done && !(rx_start && receive_enable_bit) |=> !s.slave_receiving_flag)
		else $error("slave receiving flag not cleared");
	AST_SRE_HOLD: assert property (ce && rx_start && !receive_enable_bit && !s.slave_receiving_flag |=> !s.slave_receiving_flag)
		else $error("slave receiving flag set with receive disabled");
	AST_LCK_HOLD: assert property (ce && lock_event && !lock_long_msg && !s.lock_status_flag |=> !s.lock_status_flag)
		else $error("lock flag set without long message");
	AST_LEN_HOLD: assert property (ce && !rx_start |=> $stable(s.rx_len))
		else $error("length changed outside reception start");
	AST_BUF_HOLD: assert property (ce && !rx_byte_valid |=> $stable(s.rx_buf))
		else $error("receive buffer changed without a byte");

	// state freeze and sticky interrupt status
	AST_FROZEN: assert property (!ce |=> $stable(s))
		else $error("state changed while enable low");
	AST_INT_STICKY: assert property (ce && rx_byte_valid |=> s.int_stat[`BRL_INT_RX_BYTE])
		else $error("byte event did not set its status bit");

endmodule : brl_status_regs

// file: tb/brl_engine_model.sv
/*
 * behavioural protocol engine that feeds reception, lock and command events.
 * assumes the bench calls fire() from a process aligned to rising mclk edges.
 */
`timescale 1ns/10ps

module brl_engine_model (
	// clock
	input  wire logic mclk,
	// event strobes and data
	output logic [10:0] ev,
	output logic [7:0]  rx_msg_len,
	output logic [7:0]  rx_byte,
	output logic [11:0] lock_master_addr,
	output logic        rx_addr_match,
	output logic        rx_broadcast,
	output logic        lock_long_msg
);
	// idle state: no strobe, data lines parked
	initial begin
		ev = 11'h000;
		rx_msg_len = 8'h00;
		rx_byte = 8'h00;
		lock_master_addr = 12'h000;
		rx_addr_match = 1'b0;
		rx_broadcast = 1'b0;
		lock_long_msg = 1'b0;
	end

	// one-cycle strobe k with its data, then data no longer valid
	task fire(input int k, input logic [11:0] d, input logic f);
		@(posedge mclk);
		ev <= 11'h001 << k;
		rx_msg_len <= d[7:0];
		rx_byte <= d[7:0];
		lock_master_addr <= d;
		rx_addr_match <= f;
		rx_broadcast <= ~f;
		lock_long_msg <= f;
		@(posedge mclk);
		ev <= 11'h000;
		// stale length, byte, address and long-message data inverted so nothing reads a held value by luck
		rx_msg_len <= ~d[7:0];
		rx_byte <= ~d[7:0];
		lock_master_addr <= ~d;
		lock_long_msg <= ~f;
	endtask : fire
endmodule : brl_engine_model

// file: tb/tb_brl_status_regs.sv
/*
 * self-checking bench of the status bank over axi4-lite.
 * assumes brl_regs.svh on the include path and the engine model alongside.
 */
`timescale 1ns/10ps
`include "brl_regs.svh"

module tb_brl_status_regs import brl_pkg::*;;
	logic mclk, rst_b, ce, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, irq, rx_en, rx_rdy, am, bc, lng;
	logic [7:0] awaddr, araddr, mlen, rbyte;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	logic [10:0] ev;
	logic [11:0] laddr;
	int errors, checks_done;
	localparam logic [31:0] SR = 32'h1 << `BRL_FLG_SRE, AM = 32'h1 << `BRL_FLG_AMATCH;
	localparam logic [31:0] CX = 32'h1 << `BRL_FLG_CMX, LK = 32'h1 << `BRL_FLG_LCK;

	brl_status_regs brl_status_regs_inst (.mclk(mclk), .rst_b(rst_b), .ce(ce),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.rx_start(ev[0]), .rx_msg_len(mlen), .rx_addr_match(am), .rx_broadcast(bc),
		.receive_enable_bit(rx_en), .slave_rx_done(ev[10]), .rx_byte_valid(ev[1]), .rx_byte(rbyte),
		.receive_ready_flag(rx_rdy), .lock_event(ev[2]), .lock_long_msg(lng), .lock_master_addr(laddr),
		.unlock_cond(ev[3]), .unlock_cmd(ev[4]), .cmd_master_req(ev[5]), .cmd_slave_tx(ev[6]),
		.cmd_done(ev[7]), .master_comm_done(ev[8]), .slave_tx_done(ev[9]), .irq(irq));

	brl_engine_model brl_engine_model_inst (.mclk(mclk), .ev(ev), .rx_msg_len(mlen), .rx_byte(rbyte),
		.lock_master_addr(laddr), .rx_addr_match(am), .rx_broadcast(bc), .lock_long_msg(lng));

	// clock, 100 ns period
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// compare and count
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	// axi4-lite write, offered together, held until taken
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ah, wh, ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		while (!(ad && wd)) begin
			@(negedge mclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			@(posedge mclk);
			if (ah) begin
				awvalid <= 1'b0;
				ad = 1'b1;
			end
			if (wh) begin
				wvalid <= 1'b0;
				wd = 1'b1;
			end
		end
		bready <= 1'b1;
		ah = 1'b0;
		while (!ah) begin
			@(negedge mclk);
			ah = bvalid;
			r = bresp;
			@(posedge mclk);
		end
		bready <= 1'b0;
		cmp({30'h0, r}, {30'h0, er});
	endtask : wr

	// axi4-lite read, compared with expected data and response
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic h;
		h = 1'b0;
		arvalid <= 1'b1;
		araddr <= a;
		while (!h) begin
			@(negedge mclk);
			h = arready;
			@(posedge mclk);
		end
		arvalid <= 1'b0;
		rready <= 1'b1;
		h = 1'b0;
		while (!h) begin
			@(negedge mclk);
			h = rvalid;
			if (h) begin
				cmp(rdata, e);
				cmp({30'h0, rresp}, {30'h0, er});
			end
			@(posedge mclk);
		end
		rready <= 1'b0;
	endtask : rd

	// interrupt level looked at mid-cycle
	task chk_irq(input logic e);
		@(negedge mclk);
		cmp({31'h0, irq}, {31'h0, e});
		@(posedge mclk);
	endtask : chk_irq

	// verdict
	task end_of_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test

	// watchdog well beyond the expected run of under two hundred cycles
	initial begin
		repeat (5000) @(posedge mclk);
		errors++;
		end_of_test();
	end

	// main sequence
	initial begin
		errors = 0;
		checks_done = 0;
		rst_b = 1'b0;
		ce = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		rx_en = 1'b1;
		rx_rdy = 1'b1;
		repeat (3) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		// receive-ready input idles high, so only the rx status word reads one
		for (int i = 0; i < 8; i++) rd(8'(4 * i), (i == 7) ? 32'h1 : 32'h0, `BRL_RESP_OKAY);
		for (int i = 0; i < 5; i++) wr(8'(4 * i), 32'hFF, `BRL_RESP_OKAY);
		for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0, `BRL_RESP_OKAY);
		wr(8'h40, 32'h1, `BRL_RESP_SLVERR);
		rd(8'h40, 32'h0, `BRL_RESP_SLVERR);
		// slave reception with address match
		brl_engine_model_inst.fire(0, 12'h0A5, 1'b1);
		rd(`BRL_OFF_RX_LEN, 32'hA5, `BRL_RESP_OKAY);
		rd(`BRL_OFF_RX_STAT, 32'h3, `BRL_RESP_OKAY);
		rd(`BRL_OFF_FLAGS, SR | AM, `BRL_RESP_OKAY);
		brl_engine_model_inst.fire(1, 12'h03C, 1'b0);
		rd(`BRL_OFF_RX_BUF, 32'h3C, `BRL_RESP_OKAY);
		brl_engine_model_inst.fire(1, 12'h0C3, 1'b0);
		rd(`BRL_OFF_RX_BUF, 32'hC3, `BRL_RESP_OKAY);
		// lock without a long message leaves the flag clear
		brl_engine_model_inst.fire(2, 12'hABC, 1'b0);
		rd(`BRL_OFF_FLAGS, SR | AM, `BRL_RESP_OKAY);
		brl_engine_model_inst.fire(2, 12'hABC, 1'b1);
		rd(`BRL_OFF_FLAGS, SR | AM | LK, `BRL_RESP_OKAY);
		rd(`BRL_OFF_LOCK_LOW, 32'hBC, `BRL_RESP_OKAY);
		wr(`BRL_OFF_LOCK_HIGH, 32'hFF, `BRL_RESP_OKAY);
		rd(`BRL_OFF_LOCK_HIGH, 32'h0A, `BRL_RESP_OKAY);
		brl_engine_model_inst.fire(4, 12'h000, 1'b0);
		rd(`BRL_OFF_FLAGS, SR | AM, `BRL_RESP_OKAY);
		brl_engine_model_inst.fire(2, 12'h5A1, 1'b1);
		brl_engine_model_inst.fire(3, 12'h000, 1'b0);
		rd(`BRL_OFF_FLAGS, SR | AM, `BRL_RESP_OKAY);
		// master command, then slave command
		brl_engine_model_inst.fire(5, 12'h000, 1'b0);
		rd(`BRL_OFF_FLAGS, SR | AM | CX, `BRL_RESP_OKAY);
		brl_engine_model_inst.fire(7, 12'h000, 1'b0);
		rd(`BRL_OFF_FLAGS, SR | AM | (32'h1 << `BRL_FLG_MRQ), `BRL_RESP_OKAY);
		brl_engine_model_inst.fire(8, 12'h000, 1'b0);
		rd(`BRL_OFF_FLAGS, SR | AM, `BRL_RESP_OKAY);
		brl_engine_model_inst.fire(6, 12'h000, 1'b0);
		brl_engine_model_inst.fire(7, 12'h000, 1'b0);
		rd(`BRL_OFF_FLAGS, SR | AM | (32'h1 << `BRL_FLG_SRQ), `BRL_RESP_OKAY);
		brl_engine_model_inst.fire(9, 12'h000, 1'b0);
		brl_engine_model_inst.fire(10, 12'h000, 1'b0);
		rd(`BRL_OFF_FLAGS, AM, `BRL_RESP_OKAY);
		brl_engine_model_inst.fire(5, 12'h000, 1'b0);
		rd(`BRL_OFF_FLAGS, AM, `BRL_RESP_OKAY);
		// broadcast start with receive disabled
		rx_en <= 1'b0;
		brl_engine_model_inst.fire(0, 12'h007, 1'b0);
		rd(`BRL_OFF_FLAGS, 32'h1 << `BRL_FLG_BCAST, `BRL_RESP_OKAY);
		rd(`BRL_OFF_RX_LEN, 32'h07, `BRL_RESP_OKAY);
		// frozen while enable is low: a byte strobe is not taken
		ce <= 1'b0;
		brl_engine_model_inst.fire(1, 12'h055, 1'b0);
		ce <= 1'b1;
		rd(`BRL_OFF_RX_BUF, 32'hC3, `BRL_RESP_OKAY);
		// sticky status, mask, write-one-to-clear
		rd(`BRL_OFF_INT_STAT, 32'hF, `BRL_RESP_OKAY);
		chk_irq(1'b0);
		wr(`BRL_OFF_INT_MASK, 32'h2, `BRL_RESP_OKAY);
		rd(`BRL_OFF_INT_MASK, 32'h2, `BRL_RESP_OKAY);
		chk_irq(1'b1);
		wr(`BRL_OFF_INT_STAT, 32'h2, `BRL_RESP_OKAY);
		rd(`BRL_OFF_INT_STAT, 32'hD, `BRL_RESP_OKAY);
		chk_irq(1'b0);
		// reset again in mid-run: flags, length, length-valid and interrupt status back to zero
		rst_b <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		rd(`BRL_OFF_FLAGS, 32'h0, `BRL_RESP_OKAY);
		rd(`BRL_OFF_RX_LEN, 32'h0, `BRL_RESP_OKAY);
		rd(`BRL_OFF_RX_STAT, 32'h1, `BRL_RESP_OKAY);
		rd(`BRL_OFF_INT_STAT, 32'h0, `BRL_RESP_OKAY);
		end_of_test();
	end
endmodule : tb_brl_status_regs
